// ---- rtl/flash_sp_ctrl.sv ----
// Flash self-program section control: sections, locks, halt and busy flag
// Overview of operation
// - Program instruction starts an operation only when fetched from boot loader section.
// - From boot loader section, any page may be erased or written.
// - Boot-size fuses set the application/boot loader boundary.
// - Application lock bits protect the application section independently.
// - Boot loader lock bits protect the boot loader section independently.
// - Concurrent-section operation keeps the CPU running from the halting section.
// - Halting-section operation halts the CPU for its whole duration.
// - Concurrent section is not read during its programming.
// - Busy flag reads one while concurrent section is blocked.
// - Boot loader section always lies inside the halting section.
// - Halt decision follows the target address, not the fetch address.
// - Lock pair: 11 free, 10 no write, 00 no write or cross read, 01 no cross read.
// - Target address latched at start; pointer may be reused.
`timescale 1ns/1ps
module flash_sp_ctrl #(
   parameter int ADDR_W = 16,
   parameter int PAGE_W = 7,
   parameter logic [15:0] HALT_SECTION_START = 16'hE000,
   parameter int OP_CYCLES = flash_sp_pkg::PAGE_OP_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [1:0] boot_size_fuses_i,
   input wire logic store_program_instr_i,
   input wire logic [ADDR_W-1:0] exec_addr_i,
   input wire logic [ADDR_W-1:0] prog_pointer_i,
   input wire logic program_memory_load_instr_i,
   input wire logic [ADDR_W-1:0] load_addr_i,
   input wire logic [ADDR_W-1:0] fetch_addr_i,
   output logic cpu_halt_o,
   output logic fetch_blocked_o,
   output logic load_allowed_o,
   output logic flash_start_o,
   output logic [ADDR_W-1:0] flash_addr_o,
   output logic irq_o
);
   // ****************************************
   // Section decode
   // ****************************************
   // Boot start = top of space minus 1,2,4 or 8 units of one eighth of the halting section; all at or above HALT start
   function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] sz);
      logic [ADDR_W-1:0] unit;
      unit = ADDR_W'((({ADDR_W{1'b1}}) - HALT_SECTION_START + 1) >> 3);
      boot_start = ADDR_W'({ADDR_W{1'b1}} - ((unit << (2'h3 - sz)) - 1));
   endfunction

   function automatic logic in_boot(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
      in_boot = (a >= boot_start(sz));
   endfunction

   function automatic logic in_halt_sec(input logic [ADDR_W-1:0] a);
      in_halt_sec = (a >= ADDR_W'(HALT_SECTION_START));
   endfunction

   typedef enum logic [1:0] {IDLE, PROG} state_e;

   localparam int TIMER_W_L = flash_sp_pkg::TIMER_W;
   state_e state;
   logic busy;
   logic op_halts;
   logic [TIMER_W_L-1:0] timer;
   logic [1:0] app_lock;
   logic [1:0] boot_lock;
   logic [flash_sp_pkg::IRQ_WIDTH-1:0] irq_stat;
   logic [flash_sp_pkg::IRQ_WIDTH-1:0] irq_mask;
   logic app_wr_ok;
   logic app_rd_ok;
   logic boot_wr_ok;
   logic boot_rd_ok;

   flash_sp_lock_check u_app_lock (
      .lock_bits_i(app_lock),
      .write_ok_o(app_wr_ok),
      .cross_read_ok_o(app_rd_ok)
   );
   flash_sp_lock_check u_boot_lock (
      .lock_bits_i(boot_lock),
      .write_ok_o(boot_wr_ok),
      .cross_read_ok_o(boot_rd_ok)
   );

   // ****************************************
   // Start qualification
   // ****************************************
   logic exec_in_boot;
   logic target_in_boot;
   logic target_wr_ok;
   logic start_ok;
   logic start_refused;
   always_comb begin
      exec_in_boot = in_boot(exec_addr_i, boot_size_fuses_i);
      target_in_boot = in_boot(prog_pointer_i, boot_size_fuses_i);
      target_wr_ok = target_in_boot ? boot_wr_ok : app_wr_ok;
      start_ok = store_program_instr_i && exec_in_boot && target_wr_ok && (state == IDLE);
      start_refused = store_program_instr_i && !start_ok;
   end

   // ****************************************
   // APB access
   // ****************************************
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic clr_busy;
   assign pready_o = 1'b1;
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && penable_i && !pwrite_i;
   assign clr_busy = wr_en && (paddr_i == flash_sp_pkg::ADDR_CTRL) && pwdata_i[flash_sp_pkg::CTRL_CLR_BUSY];

   always_comb begin
      addr_ok = (paddr_i == flash_sp_pkg::ADDR_CTRL) || (paddr_i == flash_sp_pkg::ADDR_STATUS) ||
                (paddr_i == flash_sp_pkg::ADDR_IRQ_STAT) || (paddr_i == flash_sp_pkg::ADDR_IRQ_MASK) ||
                (paddr_i == flash_sp_pkg::ADDR_LOCKS);
      pslverr_o = psel_i && penable_i && !addr_ok;
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= 32'h0;
         if (paddr_i == flash_sp_pkg::ADDR_STATUS) begin
            prdata_o[flash_sp_pkg::STAT_BUSY] <= busy;
            prdata_o[flash_sp_pkg::STAT_HALT] <= cpu_halt_o;
            prdata_o[flash_sp_pkg::STAT_PROG] <= (state == PROG);
         end else if (paddr_i == flash_sp_pkg::ADDR_IRQ_STAT) begin
            prdata_o[flash_sp_pkg::IRQ_WIDTH-1:0] <= irq_stat;
         end else if (paddr_i == flash_sp_pkg::ADDR_IRQ_MASK) begin
            prdata_o[flash_sp_pkg::IRQ_WIDTH-1:0] <= irq_mask;
         end else if (paddr_i == flash_sp_pkg::ADDR_LOCKS) begin
            prdata_o[3:0] <= {boot_lock, app_lock};
         end
      end
   end

   // Lock bits may only be programmed (1 to 0) by software; release needs a reset
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         app_lock <= flash_sp_pkg::LOCK_RESET;
         boot_lock <= flash_sp_pkg::LOCK_RESET;
      end else if (wr_en && paddr_i == flash_sp_pkg::ADDR_LOCKS) begin
         app_lock <= app_lock & pwdata_i[flash_sp_pkg::LOCK_APP_LO +: 2];
         boot_lock <= boot_lock & pwdata_i[flash_sp_pkg::LOCK_BOOT_LO +: 2];
      end
   end

   // ****************************************
   // Page operation sequencer
   // ****************************************
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state <= IDLE;
         timer <= '0;
         op_halts <= 1'b0;
         flash_addr_o <= '0;
         flash_start_o <= 1'b0;
      end else begin
         flash_start_o <= 1'b0;
         case (state)
            IDLE: begin
               if (start_ok) begin
                  state <= PROG;
                  flash_addr_o <= prog_pointer_i;
                  flash_start_o <= 1'b1;
                  op_halts <= in_halt_sec(prog_pointer_i);
                  timer <= TIMER_W_L'(OP_CYCLES - 1);
               end
            end
            default: begin
               if (timer == '0) begin
                  state <= IDLE;
                  op_halts <= 1'b0;
               end else begin
                  timer <= timer - 1'b1;
               end
            end
         endcase
      end
   end

   // Busy flag: set on concurrent-section start, sticky until software clear after completion
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         busy <= 1'b0;
      end else if (start_ok && !in_halt_sec(prog_pointer_i)) begin
         busy <= 1'b1;
      end else if (clr_busy && state == IDLE) begin
         busy <= 1'b0;
      end
   end

   always_comb begin
      cpu_halt_o = (state == PROG) && op_halts;
      fetch_blocked_o = busy && !in_halt_sec(fetch_addr_i);
   end

   // Cross-section loads checked against the target section's lock bits
   logic ld_in_boot;
   always_comb begin
      ld_in_boot = in_boot(load_addr_i, boot_size_fuses_i);
      load_allowed_o = program_memory_load_instr_i && !(busy && !in_halt_sec(load_addr_i));
      if (ld_in_boot && !exec_in_boot && !boot_rd_ok) begin
         load_allowed_o = 1'b0;
      end
      if (!ld_in_boot && exec_in_boot && !app_rd_ok) begin
         load_allowed_o = 1'b0;
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   logic done_evt;
   assign done_evt = (state == PROG) && (timer == '0);
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_stat <= '0;
         irq_mask <= flash_sp_pkg::IRQ_MASK_RESET;
      end else begin
         // Set beats write-one-to-clear in the same cycle
         irq_stat[flash_sp_pkg::IRQ_DONE] <= done_evt || (irq_stat[flash_sp_pkg::IRQ_DONE] &&
            !(wr_en && paddr_i == flash_sp_pkg::ADDR_IRQ_STAT && pwdata_i[flash_sp_pkg::IRQ_DONE]));
         irq_stat[flash_sp_pkg::IRQ_REFUSED] <= start_refused || (irq_stat[flash_sp_pkg::IRQ_REFUSED] &&
            !(wr_en && paddr_i == flash_sp_pkg::ADDR_IRQ_STAT && pwdata_i[flash_sp_pkg::IRQ_REFUSED]));
         if (wr_en && paddr_i == flash_sp_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= pwdata_i[flash_sp_pkg::IRQ_WIDTH-1:0];
         end
      end
   end
   assign irq_o = |(irq_stat & irq_mask);
endmodule

// ---- rtl/flash_sp_pkg.sv ----
// Package: constants for the flash self-program section control block
package flash_sp_pkg;
   // ****************************************
   // Register map (APB byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_LOCKS = 8'h10;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_CLR_BUSY = 0;
   localparam int STAT_BUSY = 0;
   localparam int STAT_HALT = 1;
   localparam int STAT_PROG = 2;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_REFUSED = 1;
   localparam int IRQ_WIDTH = 2;
   localparam int LOCK_APP_LO = 0;
   localparam int LOCK_BOOT_LO = 2;
   // ****************************************
   // Reset values and lock encodings
   // ****************************************
   localparam logic [1:0] LOCK_RESET = 2'h3;
   localparam logic [1:0] LOCK_NONE = 2'h3;
   localparam logic [1:0] LOCK_NO_WRITE = 2'h2;
   localparam logic [1:0] LOCK_ALL = 2'h0;
   localparam logic [1:0] LOCK_NO_READ = 2'h1;
   localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PAGE_OP_TIME_US = 4;
   localparam int PAGE_OP_CYCLES = (PAGE_OP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TIMER_W = 16;
endpackage

// ---- rtl/flash_sp_lock_check.sv ----
// Lock-bit access checker for one flash section
`timescale 1ns/1ps
module flash_sp_lock_check (
   input wire logic [1:0] lock_bits_i,
   output logic write_ok_o,
   output logic cross_read_ok_o
);
   // Zero bit means programmed
   always_comb begin
      write_ok_o = 1'b1;
      cross_read_ok_o = 1'b1;
      case (lock_bits_i)
         flash_sp_pkg::LOCK_NONE: begin
         end
         flash_sp_pkg::LOCK_NO_WRITE: begin
            write_ok_o = 1'b0;
         end
         flash_sp_pkg::LOCK_ALL: begin
            write_ok_o = 1'b0;
            cross_read_ok_o = 1'b0;
         end
         default: begin
            cross_read_ok_o = 1'b0;
         end
      endcase
   end
endmodule

// ---- verif/flash_sp_props.sv ----
// Checker for the flash self-program section control block
`timescale 1ns/1ps
module flash_sp_props #(
   parameter int OP_CYCLES = 8,
   parameter logic [15:0] HALT_SECTION_START = 16'hE000
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [1:0] boot_size_fuses_i,
   input wire logic store_program_instr_i,
   input wire logic [15:0] exec_addr_i,
   input wire logic [15:0] prog_pointer_i,
   input wire logic [15:0] fetch_addr_i,
   input wire logic cpu_halt_o,
   input wire logic fetch_blocked_o,
   input wire logic flash_start_o,
   input wire logic [15:0] flash_addr_o
);
   logic [16:0] boot_start;
   logic [15:0] halt_len;
   logic [15:0] concurrent_left;
   logic clr_wr;
   // Boot area grows downward from the top
   assign boot_start = 17'h10000 - (17'h00400 << (2'h3 - boot_size_fuses_i));
   assign clr_wr = psel_i && penable_i && pwrite_i && paddr_i == flash_sp_pkg::ADDR_CTRL && pwdata_i[0];
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !cpu_halt_o) begin
         halt_len <= 16'h0000;
      end else begin
         halt_len <= halt_len + 16'h0001;
      end
   end
   // Cycles left of a concurrent-section operation; busy must cover all of them
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         concurrent_left <= 16'h0000;
      end else if (flash_start_o && flash_addr_o < HALT_SECTION_START) begin
         concurrent_left <= 16'(OP_CYCLES - 1);
      end else if (concurrent_left != 16'h0000) begin
         concurrent_left <= concurrent_left - 16'h0001;
      end
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   start_boot_only_a: assert property (flash_start_o |-> $past(store_program_instr_i) &&
      {1'b0, $past(exec_addr_i)} >= $past(boot_start)) else $error("Start outside boot area");
   addr_latch_a: assert property (flash_start_o |-> flash_addr_o == $past(prog_pointer_i))
      else $error("Target not latched");
   addr_hold_a: assert property (cpu_halt_o && !flash_start_o |-> $stable(flash_addr_o))
      else $error("Target moved");
   halt_target_a: assert property (flash_start_o |-> cpu_halt_o == (flash_addr_o >= HALT_SECTION_START))
      else $error("Halt ignores target");
   halt_length_a: assert property ($fell(cpu_halt_o) |-> halt_len == OP_CYCLES)
      else $error("Halt length wrong");
   concurrent_block_a: assert property (((flash_start_o && flash_addr_o < HALT_SECTION_START) ||
      concurrent_left != 16'h0000) && fetch_addr_i < HALT_SECTION_START |-> fetch_blocked_o)
      else $error("Fetch not blocked");
   halting_fetch_free_a: assert property (fetch_addr_i >= HALT_SECTION_START |-> !fetch_blocked_o)
      else $error("Halting-section fetch blocked");
   busy_sticky_a: assert property (fetch_blocked_o && !clr_wr |=> fetch_blocked_o ||
      fetch_addr_i != $past(fetch_addr_i)) else $error("Busy dropped");
endmodule
bind flash_sp_ctrl flash_sp_props #(.OP_CYCLES(OP_CYCLES), .HALT_SECTION_START(HALT_SECTION_START)) flash_sp_props_i (
   .clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .boot_size_fuses_i,
   .store_program_instr_i, .exec_addr_i, .prog_pointer_i, .fetch_addr_i, .cpu_halt_o, .fetch_blocked_o,
   .flash_start_o, .flash_addr_o);

// ---- verif/cpu_model.sv ----
// Processor core model issuing program, load and fetch requests
`timescale 1ns/1ps
module cpu_model (
   input wire logic clk_sys_i,
   output logic store_program_instr_o,
   output logic [15:0] exec_addr_o,
   output logic [15:0] prog_pointer_o,
   output logic program_memory_load_instr_o,
   output logic [15:0] load_addr_o,
   output logic [15:0] fetch_addr_o
);
   // Code and vectors sit in the boot area
   initial begin
      {store_program_instr_o, program_memory_load_instr_o} = 2'h0;
      {exec_addr_o, prog_pointer_o, load_addr_o, fetch_addr_o} = {4{16'hFC00}};
   end
   task automatic store(input logic [15:0] ex, input logic [15:0] pt);
      @(posedge clk_sys_i);
      store_program_instr_o <= 1'b1;
      exec_addr_o <= ex;
      fetch_addr_o <= ex;
      prog_pointer_o <= pt;
      @(posedge clk_sys_i);
      store_program_instr_o <= 1'b0;
      prog_pointer_o <= ~pt;
   endtask
   // Busy-section address only after clearing, or to see it refused
   task automatic access(input logic [15:0] la, input logic [15:0] fa);
      @(posedge clk_sys_i);
      program_memory_load_instr_o <= 1'b1;
      load_addr_o <= la;
      fetch_addr_o <= fa;
   endtask
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the flash self-program section control block
`timescale 1ns/1ps
module testbench;
   typedef struct packed {logic [1:0] f; logic [3:0] lk; logic [15:0] ex; logic [15:0] pt; logic st; logic h;} row_s;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] pad = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic [1:0] fuses = 2'h3;
   logic sp, ld, rdy, err, se, halt, blk, ld_ok, start, irq;
   logic [15:0] ex, pt, la, fa, faddr;
   int failures = 0;
   int tests_run = 0;
   row_s rows [10] = '{'{2'h3, 4'hF, 16'hFC10, 16'h1000, 1'b1, 1'b0}, '{2'h3, 4'hF, 16'hF900, 16'h1000, 1'b0, 1'b0},
      '{2'h2, 4'hF, 16'hF900, 16'hFD00, 1'b1, 1'b1}, '{2'h1, 4'hF, 16'hF100, 16'hE100, 1'b1, 1'b1},
      '{2'h0, 4'hF, 16'hE010, 16'h0100, 1'b1, 1'b0}, '{2'h1, 4'hF, 16'hEF00, 16'h0100, 1'b0, 1'b0},
      '{2'h3, 4'hD, 16'hFC00, 16'h2000, 1'b1, 1'b0}, '{2'h3, 4'hC, 16'hFC00, 16'h2000, 1'b0, 1'b0},
      '{2'h3, 4'hC, 16'hFC00, 16'hFE00, 1'b1, 1'b1}, '{2'h3, 4'h8, 16'hFC00, 16'hFE00, 1'b0, 1'b0}};
   flash_sp_ctrl #(.OP_CYCLES(8)) flash_sp_ctrl_i (.clk_sys_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
      .boot_size_fuses_i(fuses), .store_program_instr_i(sp), .exec_addr_i(ex), .prog_pointer_i(pt),
      .program_memory_load_instr_i(ld), .load_addr_i(la), .fetch_addr_i(fa), .cpu_halt_o(halt),
      .fetch_blocked_o(blk), .load_allowed_o(ld_ok), .flash_start_o(start), .flash_addr_o(faddr), .irq_o(irq));
   cpu_model cpu_model_i (.clk_sys_i(clk), .store_program_instr_o(sp), .exec_addr_o(ex), .prog_pointer_o(pt),
      .program_memory_load_instr_o(ld), .load_addr_o(la), .fetch_addr_o(fa));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bound(input int n);
      chk(n < 40, 1'b1);
      if (n >= 40) end_sim();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {psel, pen, pwr, pad, pwd} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 40);
      rd = prd;
      se = err;
      {psel, pen} <= 2'h0;
      bound(n);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, flash_sp_pkg::ADDR_STATUS, 32'h0);
         n++;
      end while (rd[flash_sp_pkg::STAT_PROG] !== 1'b0 && n < 40);
      bound(n);
   endtask
   initial begin
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b1, flash_sp_pkg::ADDR_LOCKS, {28'h0, rows[i].lk});
         fuses <= rows[i].f;
         cpu_model_i.store(rows[i].ex, rows[i].pt);
         #1;
         chk(start, rows[i].st);
         chk(halt, rows[i].h);
         if (rows[i].st) chk(faddr, rows[i].pt);
         wait_idle();
         apb(1'b0, flash_sp_pkg::ADDR_IRQ_STAT, 32'h0);
         chk(rd, rows[i].st ? 32'h1 : 32'h2);
         apb(1'b1, flash_sp_pkg::ADDR_IRQ_STAT, 32'h3);
         apb(1'b1, flash_sp_pkg::ADDR_CTRL, 32'h1);
      end
      cpu_model_i.access(16'h2000, 16'hFC00);
      #1;
      chk(ld_ok, 1'b0);
      // Reset values and an unmapped address
      @(posedge clk);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, flash_sp_pkg::ADDR_LOCKS, 32'h0);
      chk(rd, {28'h0, flash_sp_pkg::LOCK_RESET, flash_sp_pkg::LOCK_RESET});
      apb(1'b0, 8'h20, 32'h0);
      chk({rd[30:0], se}, 32'h1);
      // Back-to-back request during a busy-section operation
      apb(1'b1, flash_sp_pkg::ADDR_IRQ_MASK, 32'h1);
      cpu_model_i.store(16'hFC00, 16'h0400);
      cpu_model_i.store(16'hFC00, 16'h0800);
      #1;
      chk({start, faddr}, {1'b0, 16'h0400});
      cpu_model_i.access(16'h0400, 16'h0400);
      #1;
      chk({blk, ld_ok}, 2'h2);
      wait_idle();
      chk(rd, 32'h1);
      apb(1'b0, flash_sp_pkg::ADDR_IRQ_STAT, 32'h0);
      chk({rd[30:0], irq}, 32'h7);
      cpu_model_i.access(16'h0400, 16'h0400);
      #1;
      chk({blk, ld_ok}, 2'h2);
      apb(1'b1, flash_sp_pkg::ADDR_IRQ_STAT, 32'h1);
      #1;
      chk(irq, 1'b0);
      apb(1'b1, flash_sp_pkg::ADDR_IRQ_MASK, 32'h2);
      #1;
      chk(irq, 1'b1);
      apb(1'b1, flash_sp_pkg::ADDR_CTRL, 32'h1);
      #1;
      chk({blk, ld_ok}, 2'h1);
      // Load from application code into a read-locked boot area
      cpu_model_i.store(16'h1000, 16'h2000);
      apb(1'b1, flash_sp_pkg::ADDR_LOCKS, 32'h7);
      cpu_model_i.access(16'hFD00, 16'hFD00);
      #1;
      chk(ld_ok, 1'b0);
      end_sim();
   end
endmodule
